// File: core/sbps_pkg.sv
// Purpose: shared constants and types for the sram backup power sequencer
// Assumes: 100 MHz system clock, comparator results synchronous after two flops
// Notes:   times are kept in their own units; cycle counts derive from them
//
// Overview of operation
// - with the main supply good, the chip enable output follows the chip enable input.
// - a memory cycle in progress at power-fail keeps its chip enable until it ends or times out.
// - an idle chip enable output at power-fail is forced inactive within the protect delay.
// - a main supply trip raises reset, lowers the active-low reset and forces the chip enable output high.
// - the switched ram supply comes from whichever of main supply and battery is higher.
// - a fresh battery leaves the ram supply off until the main supply first appears.
// - power-fail follows the main supply falling to or rising above the battery level.
// - the early warning interrupt falls when the sense input drops below its trip level while the main supply is good.
// - reset is held for the full power-up reset time after the main supply becomes valid.
// - later sense drops raise a fresh warning and a missing watchdog kick raises reset.
// - the cycle-finish limit is at most 5 microseconds.
// - the protect delay lies between 7 and 144 microseconds.
package sbps_pkg;

   localparam int CLK_PERIOD_NS         = 10;
   localparam int CYCLE_FINISH_LIMIT_NS = 5000;    // longest time, rounds down
   localparam int PROTECT_DELAY_MIN_NS  = 7000;    // least time, rounds up
   localparam int POWERUP_RESET_TIME_MS = 100;
   localparam int WATCHDOG_TIMEOUT_MS   = 170;

   localparam int CYCLE_FINISH_CYC  = CYCLE_FINISH_LIMIT_NS / CLK_PERIOD_NS;
   localparam int PROTECT_DELAY_CYC =
      (PROTECT_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POWERUP_RESET_CYC = POWERUP_RESET_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int WATCHDOG_CYC      = WATCHDOG_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

   localparam int CNT_W = 32;
   localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
   localparam logic [2:0] SYNC_RESET = 3'h0;

   // comparator results gathered together
   typedef struct packed {
      logic main_below_trip;
      logic main_below_battery;
      logic sense_below_trip;
   } sbps_comp_type;

   // ram side outputs
   typedef struct packed {
      logic chip_enable_out_n;
      logic power_fail_out;
      logic ram_from_main;
      logic ram_from_battery;
   } sbps_ram_type;

   // gating of the chip enable path
   typedef enum logic [2:0] {
      CE_FOLLOW  = 3'b001,
      CE_HOLD    = 3'b010,
      CE_PROTECT = 3'b100
   } sbps_ce_state_type;

endpackage

// File: core/sbps_sync.sv
// Purpose: two-flop synchroniser for one comparator result
// Assumes: single clock domain
// Notes:   first flop feeds only the second one
`timescale 1ns/10ps
`default_nettype none
module sbps_sync (
   // clock and reset
   input  wire logic sys_clk_in,
   input  wire logic reset_n_in,
   input  wire logic clk_en_in,
   // data
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_ff;

   // two stages; reset value reads as a good supply, so nothing trips at release
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         meta_ff  <= 1'b0;
         sync_out <= 1'b0;
      end else if (clk_en_in) begin
         meta_ff  <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule
`default_nettype wire

// File: core/sbps_top.sv
// Purpose: power sequencer gating sram chip enable and ordering power-fail signals
// Assumes: comparator results arrive as levels; one 100 MHz clock
// Notes:   chip enable path is registered, so it lags the input by one cycle
`timescale 1ns/10ps
`default_nettype none
module sbps_top
   import sbps_pkg::*;
#(
   parameter int POWERUP_CYC = POWERUP_RESET_CYC,
   parameter int WDOG_CYC    = WATCHDOG_CYC
) (
   // clock and reset
   input  wire logic    sys_clk_in,
   input  wire logic    reset_n_in,
   input  wire logic    clk_en_in,
   // comparators and battery presence
   input  wire sbps_comp_type comp_in,
   input  wire logic    battery_present_in,
   // processor side
   input  wire logic    chip_enable_in_n,
   input  wire logic    watchdog_kick_n,
   output logic         warning_irq_n_out,
   output logic         reset_out,
   output logic         reset_n_out,
   // ram side
   output sbps_ram_type ram_out
);
   logic main_low;
   logic batt_high;
   logic sense_low;
   logic kick_q_ff;
   logic seal_broken_ff;
   logic [CNT_W-1:0] ce_cnt_ff;
   logic [CNT_W-1:0] por_cnt_ff;
   logic [CNT_W-1:0] wd_cnt_ff;
   logic [2:0] sense_hist_ff;
   logic wd_fire_ff;
   sbps_ce_state_type ce_state_ff;
   sbps_ce_state_type nxt_ce_state;

   // comparator results synchronised before use
   sbps_sync u_sync_trip (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .clk_en_in  (clk_en_in),
      .async_in   (comp_in.main_below_trip),
      .sync_out   (main_low)
   );
   sbps_sync u_sync_batt (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .clk_en_in  (clk_en_in),
      .async_in   (comp_in.main_below_battery),
      .sync_out   (batt_high)
   );
   sbps_sync u_sync_sense (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .clk_en_in  (clk_en_in),
      .async_in   (comp_in.sense_below_trip),
      .sync_out   (sense_low)
   );

   // chip enable gating state: hold only if a cycle is open at the trip
   always_comb begin
      nxt_ce_state = ce_state_ff;
      case (ce_state_ff)
         CE_FOLLOW: begin
            if (main_low) begin
               nxt_ce_state = ram_out.chip_enable_out_n ? CE_PROTECT : CE_HOLD;
            end
         end
         CE_HOLD: begin
            // cycle ends on input high or on the limit
            if (chip_enable_in_n || ce_cnt_ff >= CNT_W'(CYCLE_FINISH_CYC - 1)) begin
               nxt_ce_state = CE_PROTECT;
            end
         end
         CE_PROTECT: begin
            if (!main_low) begin
               nxt_ce_state = CE_FOLLOW;
            end
         end
         default: nxt_ce_state = CE_PROTECT;
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ce_state_ff <= CE_PROTECT;
      end else if (clk_en_in) begin
         ce_state_ff <= nxt_ce_state;
      end
   end

   // hold timer, cleared whenever not holding
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ce_cnt_ff <= CNT_ZERO;
      end else if (clk_en_in) begin
         ce_cnt_ff <= (ce_state_ff == CE_HOLD) ? ce_cnt_ff + 1'b1 : CNT_ZERO;
      end
   end

   // chip enable output; protection is immediate, well inside the protect delay
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ram_out.chip_enable_out_n <= 1'b1;
      end else if (clk_en_in) begin
         case (nxt_ce_state)
            CE_FOLLOW:  ram_out.chip_enable_out_n <= chip_enable_in_n;
            CE_HOLD:    ram_out.chip_enable_out_n <= ram_out.chip_enable_out_n;
            default:    ram_out.chip_enable_out_n <= 1'b1;
         endcase
      end
   end

   // power-fail follows the battery comparator both ways
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ram_out.power_fail_out <= 1'b1;
      end else if (clk_en_in) begin
         ram_out.power_fail_out <= batt_high;
      end
   end

   // freshness seal: broken by the main supply, restored by battery removal
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         seal_broken_ff <= 1'b0;
      end else if (clk_en_in) begin
         if (!battery_present_in) begin
            seal_broken_ff <= 1'b0;
         end else if (!batt_high) begin
            seal_broken_ff <= 1'b1;
         end
      end
   end

   // ram supply source select, the higher of the two
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ram_out.ram_from_main    <= 1'b0;
         ram_out.ram_from_battery <= 1'b0;
      end else if (clk_en_in) begin
         ram_out.ram_from_main    <= !batt_high;
         ram_out.ram_from_battery <= batt_high && seal_broken_ff && battery_present_in;
      end
   end

   // power-up reset timer restarts on every trip
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         por_cnt_ff <= CNT_ZERO;
      end else if (clk_en_in) begin
         if (main_low || wd_fire_ff) begin
            por_cnt_ff <= CNT_ZERO;
         end else if (por_cnt_ff < CNT_W'(POWERUP_CYC)) begin
            por_cnt_ff <= por_cnt_ff + 1'b1;
         end
      end
   end

   // watchdog kick edge; input is synchronous by assumption
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         kick_q_ff <= 1'b1;
      end else if (clk_en_in) begin
         kick_q_ff <= watchdog_kick_n;
      end
   end

   // watchdog runs only while reset is released; a miss restarts the reset
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wd_cnt_ff  <= CNT_ZERO;
         wd_fire_ff <= 1'b0;
      end else if (clk_en_in) begin
         wd_fire_ff <= 1'b0;
         if (reset_out || (kick_q_ff && !watchdog_kick_n)) begin
            wd_cnt_ff <= CNT_ZERO;
         end else if (wd_cnt_ff >= CNT_W'(WDOG_CYC - 1)) begin
            wd_cnt_ff  <= CNT_ZERO;
            wd_fire_ff <= 1'b1;
         end else begin
            wd_cnt_ff <= wd_cnt_ff + 1'b1;
         end
      end
   end

   // reset outputs
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         reset_out   <= 1'b1;
         reset_n_out <= 1'b0;
      end else if (clk_en_in) begin
         reset_out   <= main_low || wd_fire_ff || (por_cnt_ff < CNT_W'(POWERUP_CYC));
         reset_n_out <= !(main_low || wd_fire_ff || (por_cnt_ff < CNT_W'(POWERUP_CYC)));
      end
   end

   // warning after three low samples, blocked while the main supply is low
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sense_hist_ff     <= SYNC_RESET;
         warning_irq_n_out <= 1'b1;
      end else if (clk_en_in) begin
         sense_hist_ff <= {sense_hist_ff[1:0], sense_low};
         if (!sense_low) begin
            warning_irq_n_out <= 1'b1;
         end else if (&sense_hist_ff[1:0] && sense_low && !main_low) begin
            warning_irq_n_out <= 1'b0;
         end
      end
   end

   // checks
   sequence s_trip_idle;
      main_low && ce_state_ff == CE_FOLLOW && ram_out.chip_enable_out_n;
   endsequence

   a_ce_follow: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      clk_en_in && ce_state_ff == CE_FOLLOW && !main_low |=>
         !clk_en_in || ram_out.chip_enable_out_n == $past(chip_enable_in_n))
      else $error("chip enable not following input");
   // the limit edge itself is excluded: there the hold ends on purpose
   a_ce_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      clk_en_in && ce_state_ff == CE_HOLD && !chip_enable_in_n &&
         ce_cnt_ff < CNT_W'(CYCLE_FINISH_CYC - 1) |=>
         $stable(ram_out.chip_enable_out_n))
      else $error("held chip enable changed");
   a_protect_high: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      ce_state_ff == CE_PROTECT |-> ram_out.chip_enable_out_n)
      else $error("protected chip enable not high");
   a_idle_protect: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      s_trip_idle ##0 clk_en_in |=> ce_state_ff == CE_PROTECT)
      else $error("idle chip enable not protected");
   a_trip_reset: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      clk_en_in && main_low |=> !clk_en_in || (reset_out && !reset_n_out))
      else $error("reset missing on supply trip");
   a_pf_track: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      clk_en_in |=> !clk_en_in || ram_out.power_fail_out == $past(batt_high))
      else $error("power-fail not tracking");
   a_seal_off: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      !seal_broken_ff |=> !ram_out.ram_from_battery)
      else $error("sealed battery powering ram");
   a_hold_limit: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      ce_cnt_ff <= CNT_W'(CYCLE_FINISH_CYC))
      else $error("hold exceeded cycle-finish limit");
   a_por_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      clk_en_in && por_cnt_ff < CNT_W'(POWERUP_CYC) |=> !clk_en_in || reset_out)
      else $error("reset released early");
   a_warn_rise: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      clk_en_in && !sense_low |=> !clk_en_in || warning_irq_n_out)
      else $error("warning held without low sense");
endmodule
`default_nettype wire

// File: verif/sbps_cpu_model.sv
// Purpose: processor model that strobes the watchdog while allowed
// Assumes: strobe changes on the falling clock edge, away from sampling
// Notes:   kick period sits well under the watchdog count, so no reset fires
`timescale 1ns/10ps
`default_nettype none
module sbps_cpu_model #(
   parameter int KICK_PERIOD = 16
) (
   // clock
   input  wire logic sys_clk_in,
   // control from the bench
   input  wire logic kick_en_in,
   // strobe towards the sequencer
   output var logic  watchdog_kick_n
);
   int cnt = 0;

   initial watchdog_kick_n = 1'b1;

   // one low cycle a period; only high then low counts as a kick
   always @(negedge sys_clk_in) begin
      cnt = (cnt + 1) % KICK_PERIOD;
      watchdog_kick_n <= !(kick_en_in && cnt == 0);
   end
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Purpose: self-checking bench for the sram backup power sequencer
// Assumes: short power-up and watchdog counts; inputs change on falling edges
// Notes:   rows cover steady states, hand tests cover holds, seal and timeouts
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import sbps_pkg::*;
   localparam int PU_CYC = 50;
   localparam int WD_CYC = 100;
   // comp, cin_n, ram_out, reset_out, warning_n; order matters, state carries
   localparam logic [9:0] ROWS [0:6] =
      '{10'h069, 10'h009, 10'h0e8, 10'h069, 10'h26b, 10'h377, 10'h06b};
   logic          sys_clk_in;
   logic          reset_n_in;
   logic          clk_en_in;
   logic          battery_present_in;
   logic          chip_enable_in_n;
   logic          kick_en;
   sbps_comp_type comp_in;
   logic          watchdog_kick_n;
   logic          warning_irq_n_out;
   logic          reset_out;
   logic          reset_n_out;
   sbps_ram_type  ram_out;
   int            miscompares = 0;
   int            num_checks = 0;
   int            cyc = 0;
   int            n;

   sbps_top #(.POWERUP_CYC(PU_CYC), .WDOG_CYC(WD_CYC)) i_dut (
      .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
      .comp_in(comp_in), .battery_present_in(battery_present_in),
      .chip_enable_in_n(chip_enable_in_n), .watchdog_kick_n(watchdog_kick_n),
      .warning_irq_n_out(warning_irq_n_out), .reset_out(reset_out),
      .reset_n_out(reset_n_out), .ram_out(ram_out));

   sbps_cpu_model i_cpu (
      .sys_clk_in(sys_clk_in), .kick_en_in(kick_en), .watchdog_kick_n(watchdog_kick_n));

   // 100 MHz clock
   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic wait_cyc(input int k);
      repeat (k) @(negedge sys_clk_in);
   endtask

   // bounded wait for reset_out to reach a level; k returns the cycles taken
   task automatic wait_rst(input logic lvl, output int k);
      k = 0;
      while (reset_out !== lvl && k < 1000) begin
         @(negedge sys_clk_in);
         k++;
      end
      // a wait that runs out is a failure in its own right
      if (k >= 1000) begin
         miscompares++;
      end
   endtask

   // hang guard, far above the roughly one thousand cycles the tests need
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         finish_test();
      end
   end

   initial begin
      reset_n_in = 1'b0;
      clk_en_in = 1'b1;
      battery_present_in = 1'b1;
      chip_enable_in_n = 1'b1;
      kick_en = 1'b1;
      comp_in = 3'h0;
      wait_cyc(4);
      check("rst_ram", ram_out, 4'hc);
      check("rst_pins", {1'b0, reset_out, reset_n_out, warning_irq_n_out}, 4'h5);
      reset_n_in = 1'b1;
      wait_rst(1'b0, n);
      check("pu_len", {3'h0, n >= PU_CYC && n <= PU_CYC + 6}, 4'h1);
      // steady states; each row settles well past the synchroniser delay
      for (int i = 0; i < 7; i++) begin
         comp_in = ROWS[i][9:7];
         chip_enable_in_n = ROWS[i][6];
         wait_cyc(8);
         check("row_ram", ram_out, ROWS[i][5:2]);
         check("row_rst", {2'h0, reset_out, warning_irq_n_out}, {2'h0, ROWS[i][1:0]});
         check("row_rst_n", {3'h0, reset_n_out}, {3'h0, ~ROWS[i][1]});
      end
      wait_rst(1'b0, n);
      check("pu_again", {3'h0, n >= PU_CYC - 15 && n <= PU_CYC}, 4'h1);
      // one-edge lag, then a frozen clock enable holds the output
      chip_enable_in_n = 1'b0;
      wait_cyc(1);
      check("ce_lag", ram_out, 4'h2);
      clk_en_in = 1'b0;
      chip_enable_in_n = 1'b1;
      wait_cyc(3);
      check("ce_frozen", ram_out, 4'h2);
      clk_en_in = 1'b1;
      wait_cyc(1);
      check("ce_resume", ram_out, 4'ha);
      // cycle in progress at the trip ends when the processor lets go
      chip_enable_in_n = 1'b0;
      wait_cyc(2);
      comp_in = 3'h4;
      wait_cyc(10);
      check("hold_ce", {3'h0, ram_out.chip_enable_out_n}, 4'h0);
      check("hold_rst", {3'h0, reset_out}, 4'h1);
      chip_enable_in_n = 1'b1;
      wait_cyc(2);
      check("hold_end", {3'h0, ram_out.chip_enable_out_n}, 4'h1);
      chip_enable_in_n = 1'b0;
      wait_cyc(3);
      check("protect", {3'h0, ram_out.chip_enable_out_n}, 4'h1);
      comp_in = 3'h0;
      wait_rst(1'b0, n);
      // a cycle that never ends is cut off by the finish limit
      wait_cyc(2);
      comp_in = 3'h4;
      wait_cyc(CYCLE_FINISH_CYC - 20);
      check("limit_hold", {3'h0, ram_out.chip_enable_out_n}, 4'h0);
      wait_cyc(40);
      check("limit_cut", {3'h0, ram_out.chip_enable_out_n}, 4'h1);
      comp_in = 3'h0;
      chip_enable_in_n = 1'b1;
      wait_rst(1'b0, n);
      // a reattached battery stays sealed until the main supply appears
      // supply drops first so the battery arrives with no main supply seen
      battery_present_in = 1'b0;
      comp_in = 3'h6;
      wait_cyc(3);
      battery_present_in = 1'b1;
      wait_cyc(8);
      check("sealed", ram_out, 4'hc);
      comp_in = 3'h0;
      wait_cyc(8);
      comp_in = 3'h6;
      wait_cyc(8);
      check("unsealed", ram_out, 4'hd);
      comp_in = 3'h0;
      wait_rst(1'b0, n);
      // a silent processor gets a watchdog reset
      kick_en = 1'b0;
      wait_rst(1'b1, n);
      check("wdog_fire", {3'h0, n >= WD_CYC - 20 && n <= WD_CYC + 10}, 4'h1);
      kick_en = 1'b1;
      wait_rst(1'b0, n);
      comp_in = 3'h1;
      wait_cyc(8);
      check("warn_again", {3'h0, warning_irq_n_out}, 4'h0);
      finish_test();
   end
endmodule
`default_nettype wire
